// ### design/bbe_pkg.sv
// bbe_pkg: shared constants, types and decode helpers for the bit and branch executor
package bbe_pkg;

  // widths and sizes
  localparam int PC_W       = 21;
  localparam int BANK_W     = 4;
  localparam int FILE_AW    = 12;
  localparam int FILE_DEPTH = 4096;

  // primary opcode nibbles (word bits 15:12)
  localparam logic [3:0] OP_BIT_CLR   = 4'h9;
  localparam logic [3:0] OP_BIT_SET   = 4'h8;
  localparam logic [3:0] OP_TEST_SKIP = 4'hB;
  localparam logic [3:0] OP_RJUMP     = 4'hD;
  localparam logic [3:0] OP_COND_GRP  = 4'hE;
  localparam logic [3:0] OP_MOVE_PFX  = 4'hC;

  // condition codes (word bits 11:8 inside the conditional group)
  localparam logic [3:0] CC_NONZERO  = 4'h1;
  localparam logic [3:0] CC_CARRY    = 4'h2;
  localparam logic [3:0] CC_NO_CARRY = 4'h3;
  localparam logic [3:0] CC_NO_OVF   = 4'h5;
  localparam logic [3:0] CC_NEG      = 4'h6;
  localparam logic [3:0] CC_NOT_NEG  = 4'h7;

  // two-word instruction prefix (word bits 15:10)
  localparam logic [5:0] LONG_PFX = 6'h3B;

  // fixed shared access bank: low half in bank 0, high half in the top bank
  localparam logic [7:0]        ACCESS_SPLIT = 8'h80;
  localparam logic [BANK_W-1:0] ACCESS_LO    = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HI    = 4'hF;

  // reset values and steps
  localparam logic [PC_W-1:0] PC_RESET     = 21'h0_0000;
  localparam logic [PC_W-1:0] PC_STEP      = 21'h0_0002;
  localparam logic [15:0]     NOP_WORD     = 16'h0000;
  localparam logic [4:0]      STATUS_RESET = 5'h00;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } bbe_status_t;

  typedef struct packed {
    logic               we;
    logic [FILE_AW-1:0] addr;
    logic [7:0]         data;
  } bbe_file_wr_t;

  typedef enum logic [2:0] {K_OTHER, K_BCLR, K_BSET, K_TSKIP, K_BCOND, K_BRA} bbe_kind_t;
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} bbe_phase_t;

  // classify one program word
  function automatic bbe_kind_t bbe_decode(input logic [15:0] w);
    bbe_kind_t k;
    k = K_OTHER;
    if (w[15:12] == OP_BIT_CLR) k = K_BCLR;
    else if (w[15:12] == OP_BIT_SET) k = K_BSET;
    else if (w[15:12] == OP_TEST_SKIP) k = K_TSKIP;
    else if (w[15:12] == OP_RJUMP && !w[11]) k = K_BRA;
    else if (w[15:12] == OP_COND_GRP && (w[11:8] == CC_NONZERO || w[11:8] == CC_CARRY ||
             w[11:8] == CC_NO_CARRY || w[11:8] == CC_NO_OVF || w[11:8] == CC_NEG ||
             w[11:8] == CC_NOT_NEG)) k = K_BCOND;
    return k;
  endfunction

  // true for the first word of a two-word instruction
  function automatic logic bbe_two_word(input logic [15:0] w);
    return (w[15:12] == OP_MOVE_PFX) || (w[15:10] == LONG_PFX);
  endfunction

  // full file address from bank select, bank flag and 8-bit register address
  function automatic logic [FILE_AW-1:0] bbe_resolve(input logic [BANK_W-1:0] bank,
                                                      input logic a, input logic [7:0] f);
    logic [BANK_W-1:0] b;
    b = a ? bank : ((f < ACCESS_SPLIT) ? ACCESS_LO : ACCESS_HI);
    return {b, f};
  endfunction

endpackage

// ### design/bbe_file_ram.sv
// bbe_file_ram: data register file, one core port and one side port, registered reads
module bbe_file_ram (
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  // core port
  input  wire bbe_pkg::bbe_file_wr_t  wr_a_in,
  input  wire logic [bbe_pkg::FILE_AW-1:0] rd_addr_a_in,
  output logic [7:0]                  rdata_a_out,
  // side port
  input  wire logic [bbe_pkg::FILE_AW-1:0] addr_b_in,
  input  wire logic                   we_b_in,
  input  wire logic [7:0]             wdata_b_in,
  output logic [7:0]                  rdata_b_out
);
  import bbe_pkg::*;

  logic [7:0] mem [0:FILE_DEPTH-1];

  // writes, core port wins a same-cycle clash
  always_ff @(posedge clk_in) begin
    if (wr_a_in.we) begin
      mem[wr_a_in.addr] <= wr_a_in.data;
    end else if (we_b_in) begin
      mem[addr_b_in] <= wdata_b_in;
    end
  end

  // registered read data on both ports
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rdata_a_out <= 8'h00;
      rdata_b_out <= 8'h00;
    end else begin
      rdata_a_out <= mem[rd_addr_a_in];
      rdata_b_out <= mem[addr_b_in];
    end
  end

endmodule

// ### design/bbe_exec.sv
// bbe_exec: quarter-phase fetch, decode and execute of the bit and branch group
//
// What this block does
// - bit clear, opcode 1001 bbba ffffffff, writes zero to the indexed bit.
// - bit set, opcode 1000, writes one, other bits unchanged.
// - bank flag 0 uses the fixed shared bank, 1 uses the bank select.
// - taken branch loads counter with incremented value plus twice the offset.
// - conditional branch takes one cycle if false, two if taken.
// - decode Q1, literal Q2, process Q3, counter Q4; extra cycle does nothing.
// - 1110 0110 branches when negative is one.
// - 1110 0011 branches when carry is zero, else falls through.
// - 1110 0111 branches when negative is zero.
// - 1110 0101 branches when overflow is zero.
// - 1110 0001 branches when zero flag is zero.
// - 1101 0 is an always-taken jump, 11-bit offset, two cycles.
// - opcode 1011 tests a bit and skips the next word when clear.
// - a skip discards the prefetched word and runs a no-op instead.
// - skipping a two-word instruction costs three cycles in total.
// - 1110 0010 branches when carry is one.
//
// Decided for this implementation: the address map and strobed register access.
module bbe_exec (
  // clock and reset
  input  wire logic                          CLOCK_IN,
  input  wire logic                          RST_N_IN,
  // program memory
  output logic [bbe_pkg::PC_W-1:0]           PROG_ADDR_OUT,
  input  wire logic [15:0]                   PROG_DATA_IN,
  // execution context
  input  wire logic [bbe_pkg::BANK_W-1:0]    BANK_SEL_IN,
  input  wire logic                          STATUS_LOAD_IN,
  input  wire bbe_pkg::bbe_status_t          STATUS_DATA_IN,
  output bbe_pkg::bbe_status_t               STATUS_OUT,
  // register file side port
  input  wire logic [bbe_pkg::FILE_AW-1:0]   FILE_ADDR_IN,
  input  wire logic                          FILE_WE_IN,
  input  wire logic [7:0]                    FILE_WDATA_IN,
  output logic [7:0]                         FILE_RDATA_OUT,
  // execution state
  output logic                               INSN_START_OUT,
  output bbe_pkg::bbe_kind_t                 EXEC_KIND_OUT,
  output logic                               NOP_CYCLE_OUT
);
  import bbe_pkg::*;

  bbe_phase_t         phase_reg;
  logic [15:0]        ir_reg;
  logic               ir_nop_reg;
  logic               extra_nop_reg;
  logic [PC_W-1:0]    pc_reg;
  logic [PC_W-1:0]    ofs_reg;
  bbe_kind_t          kind_reg;
  logic [FILE_AW-1:0] file_addr_reg;
  logic [7:0]         rd_data;
  logic [7:0]         mod_reg;
  logic               take_reg;
  logic               bit_reg;
  bbe_status_t        status_reg;
  bbe_file_wr_t       core_wr;
  logic [2:0]         bit_idx;
  logic [7:0]         bit_mask;
  logic               take_now;
  logic               skip_now;

  // bit operand fields
  assign bit_idx  = ir_reg[11:9];
  assign bit_mask = 8'h01 << bit_idx;

  // quarter phase divider, one phase per clock
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      phase_reg <= PH_Q1;
    end else begin
      unique case (phase_reg)
        PH_Q1: phase_reg <= PH_Q2;
        PH_Q2: phase_reg <= PH_Q3;
        PH_Q3: phase_reg <= PH_Q4;
        PH_Q4: phase_reg <= PH_Q1;
      endcase
    end
  end

  // decode in Q1
  // a flushed word decodes as nothing at all
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      kind_reg <= K_OTHER;
    end else if (phase_reg == PH_Q1) begin
      kind_reg <= ir_nop_reg ? K_OTHER : bbe_decode(ir_reg);
    end
  end

  // bank resolution
  // address is presented from Q1 so read data lands for Q3
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      file_addr_reg <= '0;
    end else if (phase_reg == PH_Q1) begin
      file_addr_reg <= bbe_resolve(BANK_SEL_IN, ir_reg[8], ir_reg[7:0]);
    end
  end

  // eleven-bit jump literal, eight-bit branch literal
  // offset literal read in Q2, sign extended and doubled
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      ofs_reg <= '0;
    end else if (phase_reg == PH_Q2) begin
      if (kind_reg == K_BRA) begin
        ofs_reg <= {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0};
      end else begin
        ofs_reg <= {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
      end
    end
  end

  // branch condition evaluated in Q3
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      take_reg <= 1'b0;
    end else if (phase_reg == PH_Q3) begin
      if (kind_reg == K_BRA) begin
        take_reg <= 1'b1;
      end else if (kind_reg == K_BCOND) begin
        unique case (ir_reg[11:8])
          CC_NEG:      take_reg <= status_reg.n;
          CC_NO_CARRY: take_reg <= !status_reg.c;
          CC_NOT_NEG:  take_reg <= !status_reg.n;
          CC_NO_OVF:   take_reg <= !status_reg.ov;
          CC_NONZERO:  take_reg <= !status_reg.z;
          CC_CARRY:    take_reg <= status_reg.c;
          default:     take_reg <= 1'b0;
        endcase
      end else begin
        take_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      mod_reg <= 8'h00;
      bit_reg <= 1'b0;
    end else if (phase_reg == PH_Q3) begin
      mod_reg <= (kind_reg == K_BSET) ? (rd_data | bit_mask) : (rd_data & ~bit_mask);
      bit_reg <= rd_data[bit_idx];
    end
  end

  assign skip_now = (kind_reg == K_TSKIP) && !bit_reg;
  assign take_now = take_reg && ((kind_reg == K_BCOND) || (kind_reg == K_BRA));

  always_comb begin
    core_wr.we   = (phase_reg == PH_Q4) && ((kind_reg == K_BCLR) || (kind_reg == K_BSET));
    core_wr.addr = file_addr_reg;
    core_wr.data = mod_reg;
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      pc_reg        <= PC_RESET;
      ir_reg        <= NOP_WORD;
      ir_nop_reg    <= 1'b1;
      extra_nop_reg <= 1'b0;
    end else if (phase_reg == PH_Q4) begin
      ir_reg        <= PROG_DATA_IN;
      pc_reg        <= take_now ? (pc_reg + ofs_reg) : (pc_reg + PC_STEP);
      ir_nop_reg    <= take_now || skip_now || extra_nop_reg;
      extra_nop_reg <= skip_now && bbe_two_word(PROG_DATA_IN);
    end
  end

  // flags left alone
  // only the outside arithmetic logic loads the status flags
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      status_reg <= STATUS_RESET;
    end else if (STATUS_LOAD_IN) begin
      status_reg <= STATUS_DATA_IN;
    end
  end

  // data register file
  bbe_file_ram u_file (
    .clk_in       (CLOCK_IN),
    .rst_n_in     (RST_N_IN),
    .wr_a_in      (core_wr),
    .rd_addr_a_in (file_addr_reg),
    .rdata_a_out  (rd_data),
    .addr_b_in    (FILE_ADDR_IN),
    .we_b_in      (FILE_WE_IN),
    .wdata_b_in   (FILE_WDATA_IN),
    .rdata_b_out  (FILE_RDATA_OUT)
  );

  // outputs
  assign PROG_ADDR_OUT  = pc_reg;
  assign STATUS_OUT     = status_reg;
  assign INSN_START_OUT = (phase_reg == PH_Q1);
  assign EXEC_KIND_OUT  = kind_reg;
  assign NOP_CYCLE_OUT  = ir_nop_reg;

  // checks on the executed behaviour
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RST_N_IN);

  a_clear_bit_write: assert property (
    phase_reg == PH_Q4 && kind_reg == K_BCLR |->
      core_wr.we && core_wr.data == ($past(rd_data) & ~bit_mask))
    else $error("bit clear wrote wrong data");

  a_set_bit_write: assert property (
    phase_reg == PH_Q4 && kind_reg == K_BSET |->
      core_wr.we && core_wr.data == ($past(rd_data) | bit_mask))
    else $error("bit set wrote wrong data");

  a_bank_pick: assert property (
    phase_reg == PH_Q1 && !ir_nop_reg |=>
      file_addr_reg[11:8] == ($past(ir_reg[8]) ? $past(BANK_SEL_IN) :
                               ($past(ir_reg[7]) ? ACCESS_HI : ACCESS_LO)))
    else $error("register bank resolved wrongly");

  a_branch_target: assert property (
    phase_reg == PH_Q4 && take_now |=> pc_reg == $past(pc_reg) + $past(ofs_reg))
    else $error("taken branch target wrong");

  a_untaken_step: assert property (
    phase_reg == PH_Q4 && kind_reg == K_BCOND && !take_reg |=>
      !ir_nop_reg && pc_reg == $past(pc_reg) + PC_STEP)
    else $error("untaken branch did not fall through");

  a_nop_quiet: assert property (
    phase_reg == PH_Q4 && ir_nop_reg |-> kind_reg == K_OTHER && !core_wr.we && !take_now)
    else $error("flushed cycle did work");

  a_neg_branch: assert property (
    phase_reg == PH_Q3 && kind_reg == K_BCOND && ir_reg[11:8] == CC_NEG |=>
      take_reg == $past(status_reg.n))
    else $error("negative branch decision wrong");

  a_nocarry_branch: assert property (
    phase_reg == PH_Q3 && kind_reg == K_BCOND && ir_reg[11:8] == CC_NO_CARRY |=>
      take_reg == !$past(status_reg.c))
    else $error("no carry branch decision wrong");

  a_notneg_branch: assert property (
    phase_reg == PH_Q3 && kind_reg == K_BCOND && ir_reg[11:8] == CC_NOT_NEG |=>
      take_reg == !$past(status_reg.n))
    else $error("not negative branch decision wrong");

  a_noovf_branch: assert property (
    phase_reg == PH_Q3 && kind_reg == K_BCOND && ir_reg[11:8] == CC_NO_OVF |=>
      take_reg == !$past(status_reg.ov))
    else $error("no overflow branch decision wrong");

  a_nonzero_branch: assert property (
    phase_reg == PH_Q3 && kind_reg == K_BCOND && ir_reg[11:8] == CC_NONZERO |=>
      take_reg == !$past(status_reg.z))
    else $error("nonzero branch decision wrong");

  a_jump_two_cycle: assert property (
    phase_reg == PH_Q4 && kind_reg == K_BRA |-> take_now ##1 ir_nop_reg[*4] ##1 !ir_nop_reg)
    else $error("relative jump not two cycles");

  a_skip_on_clear: assert property (
    phase_reg == PH_Q3 && kind_reg == K_TSKIP && !rd_data[bit_idx] |=> ##1 ir_nop_reg[*4])
    else $error("clear bit did not skip");

  a_no_skip_set: assert property (
    phase_reg == PH_Q4 && kind_reg == K_TSKIP && bit_reg |=> !ir_nop_reg)
    else $error("set bit skipped");

  a_long_skip: assert property (
    phase_reg == PH_Q4 && skip_now && bbe_two_word(PROG_DATA_IN) |=>
      ir_nop_reg[*8] ##1 !ir_nop_reg)
    else $error("long skip not three cycles");

  a_skip_flush: assert property (
    phase_reg == PH_Q4 && skip_now |=> ir_nop_reg ##1 kind_reg == K_OTHER)
    else $error("skipped word was decoded");

  a_phase_wrap: assert property (
    phase_reg == PH_Q4 |=> phase_reg == PH_Q1)
    else $error("phase did not wrap to q1");

  a_carry_branch: assert property (
    phase_reg == PH_Q3 && kind_reg == K_BCOND && ir_reg[11:8] == CC_CARRY |=>
      take_reg == $past(status_reg.c))
    else $error("carry branch decision wrong");

  a_status_hold: assert property (
    !STATUS_LOAD_IN |=> status_reg == $past(status_reg))
    else $error("status changed without a load");

  a_rmw_phase: assert property (
    core_wr.we |-> phase_reg == PH_Q4 && $past(phase_reg, 2) == PH_Q2)
    else $error("register write outside Q4");

  // main scenarios
  c_taken_branch: cover property (phase_reg == PH_Q4 && take_now && kind_reg == K_BCOND);
  c_skip: cover property (phase_reg == PH_Q4 && skip_now);
  c_long_skip: cover property (phase_reg == PH_Q4 && skip_now && bbe_two_word(PROG_DATA_IN));
  c_bit_write: cover property (core_wr.we && kind_reg == K_BSET);
  c_jump: cover property (phase_reg == PH_Q4 && take_now && kind_reg == K_BRA);

endmodule

// ### dv/tb.sv
// tb: self-checking bench for the bit and branch executor
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import bbe_pkg::*;

  typedef struct {int cyc; logic [PC_W-1:0] pc; logic no_operation; bbe_status_t st;} bbe_note_t;
  typedef struct {int cyc; bbe_kind_t k;} bbe_knote_t;

  localparam logic [PC_W-1:0] S = 21'h0_0020;  // first test word
  localparam int              E = 17;          // cycle that executes it

  // design stimulus and observation
  logic                clk;
  logic                rst_n;
  logic                st_ld;
  logic                fwe;
  logic                rd_v;
  logic                rd_d;
  logic                start;
  logic                nopc;
  logic [15:0]         pdata;
  logic [3:0]          bank;
  logic [7:0]          fwd;
  logic [7:0]          frd;
  logic [FILE_AW-1:0]  faddr;
  logic [PC_W-1:0]     paddr;
  bbe_status_t         st_in;
  bbe_status_t         st_o;
  bbe_status_t         exp_st;
  bbe_kind_t           kind;
  logic [15:0]         prog [0:4095];
  bbe_note_t           tq [$];
  bbe_knote_t          kq [$];
  logic [7:0]          rq [$];
  int                  cyc;
  int                  error_cnt;
  int                  n_tests;

  bbe_exec i_bbe_exec (
    .CLOCK_IN       (clk),
    .RST_N_IN       (rst_n),
    .PROG_ADDR_OUT  (paddr),
    .PROG_DATA_IN   (pdata),
    .BANK_SEL_IN    (bank),
    .STATUS_LOAD_IN (st_ld),
    .STATUS_DATA_IN (st_in),
    .STATUS_OUT     (st_o),
    .FILE_ADDR_IN   (faddr),
    .FILE_WE_IN     (fwe),
    .FILE_WDATA_IN  (fwd),
    .FILE_RDATA_OUT (frd),
    .INSN_START_OUT (start),
    .EXEC_KIND_OUT  (kind),
    .NOP_CYCLE_OUT  (nopc)
  );

  // clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // program memory answers the fetch address, settled long before the q4 edge
  always @(posedge clk) begin
    pdata <= prog[paddr[12:1]];
    rd_d  <= rd_v;
  end

  // one comparison, counted
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s mismatch", $time, m);
    end
  endtask

  // monitor: one trace note per instruction cycle, one note per readback
  always @(negedge clk) begin
    bbe_note_t  n;
    bbe_knote_t m;
    if (rst_n !== 1'b1) cyc = -1;
    else if (start === 1'b1) begin
      cyc++;
      if (tq.size() > 0 && tq[0].cyc == cyc) begin
        n = tq.pop_front();
        chk(paddr === n.pc && nopc === n.no_operation && st_o === n.st, "trace");
      end
      // kind shown in q1 is that of the previous cycle
      if (kq.size() > 0 && kq[0].cyc == cyc) begin
        m = kq.pop_front();
        chk(kind === m.k, "kind");
      end
    end
    if (rd_d === 1'b1) chk(frd === rq.pop_front(), "readback");
  end

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // expected fetch address and flush flag for len cycles from cycle c
  task automatic flow(input int c, input logic [PC_W-1:0] a, input int nops, input int len);
    for (int k = 0; k < len; k++) tq.push_back('{c + k, a + PC_W'(2 * k), k < nops, exp_st});
  endtask

  // expected decoded kind seen at the start of cycle c
  task automatic kx(input int c, input bbe_kind_t k);
    kq.push_back('{c, k});
  endtask

  // straight-line no-op lead-in up to the first test word
  task automatic lead;
    flow(1, PC_STEP, 0, E);
  endtask

  // reset for 4 cycles with a clean program and fresh context
  task automatic begin_test;
    @(posedge clk);
    rst_n <= 1'b0;
    bank  <= 4'($urandom_range(14, 1));
    foreach (prog[i]) prog[i] = NOP_WORD;
    exp_st = STATUS_RESET;
    flow(0, PC_RESET, 1, 1);
    exp_st = bbe_status_t'(5'($urandom));
    repeat (4) @(posedge clk);
  endtask

  // release reset, then load the flags
  task automatic release_rst;
    rst_n <= 1'b1;
    @(posedge clk);
    st_in <= exp_st;
    st_ld <= 1'b1;
    @(posedge clk);
    st_ld <= 1'b0;
  endtask

  task automatic wr(input logic [FILE_AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    faddr <= a;
    fwd   <= d;
    fwe   <= 1'b1;
    @(posedge clk);
    fwe   <= 1'b0;
  endtask

  task automatic rd(input logic [FILE_AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    faddr <= a;
    rd_v  <= 1'b1;
    rq.push_back(d);
    @(posedge clk);
    rd_v  <= 1'b0;
  endtask

  // bounded wait for cycle c; leftover notes count as a mismatch
  task automatic wait_done(input int c);
    int k;
    for (k = 0; k < 400 && cyc < c; k++) @(posedge clk);
    if (k == 400 || tq.size() != 0 || kq.size() != 0) begin
      error_cnt++;
      $display("unexpected at %0t: trace stalled or incomplete", $time);
      end_of_test();
    end
  endtask

  function automatic logic tk(input int cc, input bbe_status_t s);
    case (4'(cc))
      CC_NONZERO:  return !s.z;
      CC_CARRY:    return s.c;
      CC_NO_CARRY: return !s.c;
      CC_NO_OVF:   return !s.ov;
      CC_NEG:      return s.n;
      CC_NOT_NEG:  return !s.n;
      default:     return 1'b0;
    endcase
  endfunction

  // main sequence
  initial begin
    logic [10:0]        off;
    logic [7:0]         f;
    logic [7:0]         v;
    logic [7:0]         e;
    logic [2:0]         b1;
    logic [2:0]         b2;
    logic               a;
    logic [FILE_AW-1:0] ra;
    logic [FILE_AW-1:0] wa;
    rst_n = 1'b0; st_ld = 1'b0; st_in = '0; fwe = 1'b0; rd_v = 1'b0; rd_d = 1'b0;
    faddr = '0; fwd = '0; bank = '0; pdata = '0; exp_st = '0;
    error_cnt = 0; n_tests = 0; cyc = -1;
    void'($urandom(39));
    // conditional branches, every code both ways, offset extremes
    for (int cc = 0; cc < 8; cc++) begin
      for (int t = 0; t < 2; t++) begin
        begin_test();
        if (tk(cc, exp_st) != t[0]) exp_st = bbe_status_t'(~exp_st);
        off = (cc == 1) ? 11'h080 : (cc == 2) ? 11'h07F : 11'($urandom);
        // an offset of minus one would land back on the branch itself
        if (off[7:0] == 8'hFF) off[7:0] = 8'hFE;
        prog[S[12:1]] = {OP_COND_GRP, 4'(cc), off[7:0]};
        lead();
        kx(E + 1, (cc == 0 || cc == 4) ? K_OTHER : K_BCOND);
        if (tk(cc, exp_st)) flow(E + 1, S + PC_STEP + {{12{off[7]}}, off[7:0], 1'b0}, 1, 3);
        else flow(E + 1, S + 21'h0_0004, 0, 3);
        release_rst();
        wait_done(E + 4);
      end
    end
    $display("test conditional branches done");
    // unconditional jump, both offset extremes and one random
    for (int i = 0; i < 3; i++) begin
      begin_test();
      off = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($urandom);
      if (off == 11'h7FF) off = 11'h7FE;
      prog[S[12:1]] = {OP_RJUMP, 1'b0, off};
      lead();
      kx(E + 1, K_BRA);
      kx(E + 2, K_OTHER);
      flow(E + 1, S + PC_STEP + {{9{off[10]}}, off, 1'b0}, 1, 3);
      release_rst();
      wait_done(E + 4);
    end
    $display("test relative jump done");
    // back-to-back clear and set on one register, both banks, both halves
    for (int i = 0; i < 8; i++) begin
      begin_test();
      f = {i[2], 7'($urandom)}; a = i[0]; v = $urandom; b1 = $urandom; b2 = $urandom;
      ra = a ? {bank, f} : {(f[7] ? ACCESS_HI : ACCESS_LO), f};
      wa = a ? {(f[7] ? ACCESS_HI : ACCESS_LO), f} : {bank, f};
      prog[S[12:1]] = {(i[1] ? OP_BIT_CLR : OP_BIT_SET), b1, a, f};
      prog[S[12:1] + 1] = {(i[1] ? OP_BIT_SET : OP_BIT_CLR), b2, a, f};
      e = v;
      e[b1] = !i[1];
      e[b2] = i[1];
      lead();
      flow(E + 1, S + 21'h0_0004, 0, 3);
      kx(E + 1, i[1] ? K_BCLR : K_BSET);
      kx(E + 2, i[1] ? K_BSET : K_BCLR);
      release_rst();
      wr(ra, v);
      wr(wa, v);
      wait_done(E + 4);
      rd(ra, e);
      rd(wa, v);
    end
    $display("test bit clear and set done");
    // test and skip: no skip, one-word skip, two kinds of two-word skip
    for (int i = 0; i < 4; i++) begin
      begin_test();
      f = $urandom; a = $urandom; b1 = $urandom; v = $urandom;
      v[b1] = (i == 0);
      ra = a ? {bank, f} : {(f[7] ? ACCESS_HI : ACCESS_LO), f};
      wa = a ? {(f[7] ? ACCESS_HI : ACCESS_LO), f} : {bank, f};
      prog[S[12:1]] = {OP_TEST_SKIP, b1, a, f};
      prog[S[12:1] + 1] = (i == 2) ? {OP_MOVE_PFX, 12'($urandom)} :
                          (i == 3) ? {LONG_PFX, 10'($urandom)} : {OP_RJUMP, 1'b0, 11'h010};
      lead();
      if (i == 0) begin
        flow(E + 1, S + 21'h0_0004, 0, 1);
        flow(E + 2, S + 21'h0_0024, 1, 2);
      end
      else flow(E + 1, S + 21'h0_0004, (i == 1) ? 1 : 2, 3);
      kx(E + 1, K_TSKIP);
      kx(E + 2, (i == 0) ? K_BRA : K_OTHER);
      release_rst();
      wr(ra, v);
      wr(wa, v ^ (8'h01 << b1));
      wait_done(E + 4);
      rd(ra, v);
    end
    $display("test skip if clear done");
    end_of_test();
  end
endmodule
